/* File: bench/mscp_engine_model.sv */
// converter, transform engine and pin model: completion and rotation-start strobes and pin levels
// assumes callers step in right after a rising clock edge
`timescale 1ns/10ps
module mscp_engine_model
(
  // clock
  input  wire logic       aclk,
  // engine strobes
  output logic            conv_done,
  output logic            rot_done,
  output logic            rot_start,
  // pin levels
  output logic [5:0]      dio_in
);
  initial
  begin
    {conv_done, rot_done, rot_start} = 3'h0;
    dio_in = 6'h00;
  end

  // one cycle wide: a longer strobe counts as several events
  task automatic pulse(input logic [2:0] which, input int dly);
    repeat (dly) @(posedge aclk);
    {conv_done, rot_done, rot_start} <= which;
    @(posedge aclk);
    {conv_done, rot_done, rot_start} <= 3'h0;
  endtask

  task automatic pins(input logic [5:0] v);
    dio_in <= v;
  endtask
endmodule

/* File: bench/mscp_regs_assertions.sv */
// checker for the register bank: interrupt pin against engine events and status reads
// assumes the host offers write address and data together, full strobes
`timescale 1ns/10ps
module mscp_regs_assertions
  import mscp_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [4:0]  s_axi_awaddr,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [4:0]  s_axi_araddr,
  // events, pins, interrupt
  input wire logic        conv_done,
  input wire logic        rot_done,
  input wire logic [5:0]  dio_in,
  input wire logic        irq_n
);
  logic [3:0]  e_ff;
  logic [17:0] d_ff;
  logic [17:0] w1_ff;
  logic [23:0] sh_ff;
  logic [5:0]  chg;
  logic        wr_hs, rd_sts, lvl, cv_ev, rt_ev, dio_ev, any_ev;

  assign wr_hs  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign rd_sts = s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_SYS_STATUS;
  assign lvl    = sh_ff[CTL_IRQ_LEVEL];
  assign cv_ev  = e_ff[3] && sh_ff[CTL_CONV_IE];
  assign rt_ev  = e_ff[2] && sh_ff[CTL_ROT_IE];
  assign chg    = d_ff[11:6] ^ d_ff[17:12];
  assign dio_ev = |(chg & ~sh_ff[17:12] & sh_ff[23:18]);
  assign any_ev = cv_ev || rt_ev || dio_ev;

  // mirrors the two synchronising stages; register lands one edge after handshake
  always_ff @(posedge aclk)
  begin
    e_ff  <= {e_ff[1:0], conv_done, rot_done};
    d_ff  <= {d_ff[11:0], dio_in};
    w1_ff <= {wr_hs, s_axi_awaddr, s_axi_wdata[11:0]};
    if (!aresetn)
      sh_ff <= 24'h000000;
    else if (w1_ff[17] && w1_ff[16:12] == ADDR_SYS_CONTROL)
      sh_ff[11:0] <= w1_ff[11:0] & CTL_WR_MASK;
    else if (w1_ff[17] && w1_ff[16:12] == ADDR_DIO_CONTROL)
      sh_ff[23:12] <= w1_ff[11:0];
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_held;
    lvl && !irq_n;
  endsequence
  sequence s_quiet_read;
    lvl && rd_sts && !any_ev;
  endsequence

  a_conv_irq_raise: assert property (cv_ev |=> !irq_n)
    else $error("no interrupt after conversion event");
  a_rot_irq_raise: assert property (rt_ev |=> !irq_n)
    else $error("no interrupt after rotation event");
  a_pin_irq_raise: assert property (dio_ev |=> !irq_n)
    else $error("no interrupt after pin change");
  a_pulse_release: assert property (!lvl && !any_ev |=> irq_n)
    else $error("pulse interrupt longer than one cycle");
  a_level_hold: assert property (s_held ##0 !rd_sts && !$past(rd_sts) |=> !irq_n)
    else $error("level interrupt released without status read");
  a_read_release: assert property (s_quiet_read |-> ##[1:2] irq_n)
    else $error("status read did not release interrupt");
  a_output_no_irq: assert property (!lvl && !any_ev && |(chg & sh_ff[17:12]) |=> irq_n)
    else $error("output pin change raised interrupt");
  a_reset_irq_idle: assert property ($rose(aresetn) |-> irq_n)
    else $error("interrupt active after reset");
endmodule

bind mscp_regs mscp_regs_assertions i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_arvalid,
  .s_axi_arready, .s_axi_araddr, .conv_done, .rot_done, .dio_in, .irq_n);

/* File: bench/mscp_regs_test.sv */
// self-checking bench for the register bank, one task a scenario
// assumes the engine model drives events and pins and the checker is bound
`timescale 1ns/10ps
module mscp_regs_test
  import mscp_pkg::*;
;
  logic           aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1;
  logic           s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic           s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [4:0]     s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0]    s_axi_wdata = 32'h0;
  logic [3:0]     s_axi_wstrb = 4'hf;
  logic           s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0]    s_axi_rdata, rd;
  logic [1:0]     s_axi_bresp, s_axi_rresp, rs;
  logic           conv_done, rot_done, rot_start, rev_3of3, sysclk_div, irq_n;
  logic [5:0]     dio_in, dio_out, dio_oe;
  mscp_conv_sel_t conv_sel;
  int             num_errors = 0, comparisons = 0, cycles = 0, n;

  mscp_regs i_dut (.aclk, .aresetn, .clk_en, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .conv_done, .rot_done, .rot_start, .dio_in,
    .dio_out, .dio_oe, .conv_sel, .rev_3of3, .sysclk_div, .irq_n);
  mscp_engine_model i_eng (.aclk, .conv_done, .rot_done, .rot_start, .dio_in);

  always #50 aclk = ~aclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // address and data released separately, each when taken
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw || w)
    begin
      @(posedge aclk);
      aw = aw && (s_axi_awready !== 1'b1);
      w = w && (s_axi_wready !== 1'b1);
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask

  task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic lows(input int cnt);
    n = 0;
    repeat (cnt)
    begin
      @(posedge aclk);
      n += int'(irq_n === 1'b0);
    end
  endtask

  task automatic t_regs;
    check(dio_oe, 6'h00);
    axi_rd(ADDR_SYS_STATUS, rd, rs);
    check(rd, 32'h0);
    axi_wr(ADDR_SYS_CONTROL, 32'hfff, rs);
    check(rs, RESP_OKAY);
    axi_rd(ADDR_SYS_CONTROL, rd, rs);
    check(rd, 32'h5fb);
    for (int i = 0; i < 4; i++)
    begin
      axi_wr(ADDR_SYS_CONTROL, {20'h0, 1'b0, i[1], 4'h0, i[0], i[1], i[0], 1'b0, i[0], i[1]},
             rs);
      check(conv_sel, {i[0], i[1], i[1:0]});
      check(sysclk_div, i[0]);
      check(rev_3of3, i[1]);
    end
    axi_wr(5'h10, 32'h5, rs);
    check(rs, RESP_SLVERR);
    axi_rd(5'h10, rd, rs);
    check(rd, 32'h0);
    check(rs, RESP_SLVERR);
    $display("t_regs finished");
  endtask

  task automatic t_pulse;
    axi_wr(ADDR_SYS_CONTROL, 32'h0c0, rs);
    i_eng.pulse(3'b100, 0);
    lows(8);
    check(n, 1);
    axi_rd(ADDR_SYS_STATUS, rd, rs);
    check(rd, 32'h801);
    axi_rd(ADDR_SYS_STATUS, rd, rs);
    check(rd, 32'h0);
    i_eng.pulse(3'b010, 3);
    lows(10);
    check(n, 1);
    axi_rd(ADDR_SYS_STATUS, rd, rs);
    check(rd, 32'h812);
    axi_rd(ADDR_SYS_STATUS, rd, rs);
    check(rd, 32'h010);
    $display("t_pulse finished");
  endtask

  task automatic t_level;
    axi_wr(ADDR_SYS_CONTROL, 32'h1c0, rs);
    i_eng.pulse(3'b100, 0);
    repeat (12) @(posedge aclk);
    check(irq_n, 1'b0);
    axi_rd(ADDR_SYS_STATUS, rd, rs);
    check(rd, 32'h811);
    repeat (2) @(posedge aclk);
    check(irq_n, 1'b1);
    $display("t_level finished");
  endtask

  task automatic t_mask;
    axi_wr(ADDR_SYS_CONTROL, 32'h000, rs);
    i_eng.pulse(3'b110, 1);
    lows(10);
    check(n, 0);
    axi_rd(ADDR_SYS_STATUS, rd, rs);
    check(rd, 32'h010);
    // a new rotation start drops results-valid, raises nothing
    i_eng.pulse(3'b001, 0);
    lows(6);
    check(n, 0);
    axi_rd(ADDR_SYS_STATUS, rd, rs);
    check(rd, 32'h000);
    $display("t_mask finished");
  endtask

  // pin 0 driven, pin 4 an unwatched input, pin 5 a watched input
  task automatic t_dio;
    axi_wr(ADDR_DIO_CONTROL, 32'h801, rs);
    axi_wr(ADDR_DIO_VALUE, 32'h2a, rs);
    check({dio_oe, dio_out}, {6'h01, 6'h2a});
    i_eng.pins(6'h11);
    lows(8);
    check(n, 0);
    i_eng.pins(6'h31);
    lows(8);
    check(n, 1);
    // input pins read back the pin level, output pins the driven value
    axi_rd(ADDR_DIO_VALUE, rd, rs);
    check(rd, 32'h30);
    axi_rd(ADDR_SYS_STATUS, rd, rs);
    check(rd & 32'hffffffef, 32'h804);
    $display("t_dio finished");
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // whole run is under two hundred cycles
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      give_verdict;
    end
  end

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_pulse;
    t_level;
    t_mask;
    t_dio;
    give_verdict;
  end
endmodule

/* File: hdl/mscp_pkg.sv */
// package for the system control, status and digital i/o register bank
// assumes an axi4-lite host with 32-bit data and one aligned word per register
package mscp_pkg;

  // register byte addresses
  localparam logic [4:0]  ADDR_SYS_CONTROL = 5'h00;
  localparam logic [4:0]  ADDR_SYS_STATUS  = 5'h04;
  localparam logic [4:0]  ADDR_DIO_CONTROL = 5'h08;
  localparam logic [4:0]  ADDR_DIO_VALUE   = 5'h0c;

  localparam int          REG_W            = 12;
  localparam int          DIO_W            = 6;

  // system control fields
  localparam int          CTL_AUX_SEL0     = 0;
  localparam int          CTL_AUX_SEL1     = 1;
  localparam int          CTL_U_EN         = 3;
  localparam int          CTL_AUX_EN       = 4;
  localparam int          CTL_CLK_HALF     = 5;
  localparam int          CTL_ROT_IE       = 6;
  localparam int          CTL_CONV_IE      = 7;
  localparam int          CTL_IRQ_LEVEL    = 8;
  localparam int          CTL_REV_3OF3     = 10;
  localparam logic [11:0] CTL_WR_MASK      = 12'h5fb;
  localparam logic [11:0] CTL_RESET        = 12'h000;

  // system status fields
  localparam int          STS_CONV_DONE    = 0;
  localparam int          STS_ROT_DONE     = 1;
  localparam int          STS_DIO_CHG      = 2;
  localparam int          STS_RES_VALID    = 4;
  localparam int          STS_IRQ_MINE     = 11;

  // digital i/o control fields
  localparam int          DIO_DIR_LSB      = 0;
  localparam int          DIO_IE_LSB       = 6;
  localparam logic [11:0] DIO_RESET        = 12'h000;

  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  typedef struct packed {
    logic       u_en;
    logic       aux_en;
    logic [1:0] aux_num;
  } mscp_conv_sel_t;

  typedef enum logic [2:0] {
    MSCP_IDLE = 3'b001,
    MSCP_WRSP = 3'b010,
    MSCP_DONE = 3'b100
  } mscp_wr_state_t;

  typedef struct packed {
    mscp_wr_state_t      wst;
    logic                awready;
    logic                wready;
    logic                aw_got;
    logic                w_got;
    logic [4:0]          aw_addr;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
    logic [REG_W-1:0]    ctl;
    logic [REG_W-1:0]    dio_ctl;
    logic [DIO_W-1:0]    dio_out;
    logic                sts_conv;
    logic                sts_rot;
    logic                sts_dio;
    logic                sts_valid;
    logic                sts_mine;
    logic                irq_hold;
    logic                irq_n;
    logic [DIO_W-1:0]    dio_s1;
    logic [DIO_W-1:0]    dio_s2;
    logic [DIO_W-1:0]    dio_prev;
    logic                conv_done_s1;
    logic                conv_done_s2;
    logic                rot_done_s1;
    logic                rot_done_s2;
    logic                rot_start_s1;
    logic                rot_start_s2;
    logic                sysclk_div;
    mscp_conv_sel_t      conv_sel;
    logic                rev_3of3;
    logic [DIO_W-1:0]    dio_oe;
  } mscp_state_t;

endpackage

/* File: hdl/mscp_regs.sv */
// system control, status and digital i/o register bank behind axi4-lite
// assumes converter and transform engine report done as levels/pulses from
// outside this clock domain, and that the pad ring resolves the i/o pins
`timescale 1ns/10ps
module mscp_regs
  import mscp_pkg::*;
(
  // clock, reset, enable
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              clk_en,
  // axi4-lite write address and data
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [4:0]        s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  // axi4-lite write response
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  // axi4-lite read
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [4:0]        s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  // engine events, asynchronous
  input  wire logic              conv_done,
  input  wire logic              rot_done,
  input  wire logic              rot_start,
  // digital i/o pins
  input  wire logic [DIO_W-1:0]  dio_in,
  output logic [DIO_W-1:0]       dio_out,
  output logic [DIO_W-1:0]       dio_oe,
  // engine configuration
  output mscp_conv_sel_t         conv_sel,
  output logic                   rev_3of3,
  output logic                   sysclk_div,
  // interrupt pin
  output logic                   irq_n
);

  mscp_state_t q_ff;
  mscp_state_t nxt_q;

  logic             wr_fire;
  logic             rd_fire;
  logic             sts_read;
  logic             ev_conv;
  logic             ev_rot;
  logic             ev_dio;
  logic             ev_any;
  logic [DIO_W-1:0] chg;
  logic [11:0]      wmask;
  logic [11:0]      rd_val;
  logic             rd_ok;

  always_comb
  begin
    nxt_q = q_ff;
    wr_fire = 1'b0;
    rd_fire = 1'b0;
    sts_read = 1'b0;
    rd_val = 12'h000;
    rd_ok = 1'b1;
    wmask = {{4{q_ff.w_strb[1]}}, {8{q_ff.w_strb[0]}}};

    // synchronisers: first stage read only by second
    nxt_q.dio_s1 = dio_in;
    nxt_q.dio_s2 = q_ff.dio_s1;
    nxt_q.dio_prev = q_ff.dio_s2;
    nxt_q.conv_done_s1 = conv_done;
    nxt_q.conv_done_s2 = q_ff.conv_done_s1;
    nxt_q.rot_done_s1 = rot_done;
    nxt_q.rot_done_s2 = q_ff.rot_done_s1;
    nxt_q.rot_start_s1 = rot_start;
    nxt_q.rot_start_s2 = q_ff.rot_start_s1;

    // input pins only, enabled ones only
    chg = (q_ff.dio_s2 ^ q_ff.dio_prev)
        & q_ff.dio_ctl[DIO_IE_LSB +: DIO_W]
        & ~q_ff.dio_ctl[DIO_DIR_LSB +: DIO_W];
    ev_conv = q_ff.conv_done_s2 & q_ff.ctl[CTL_CONV_IE];
    ev_rot = q_ff.rot_done_s2 & q_ff.ctl[CTL_ROT_IE];
    ev_dio = |chg;
    ev_any = ev_conv | ev_rot | ev_dio;

    // write channel: address and data in either order
    if (s_axi_awvalid && q_ff.awready)
    begin
      nxt_q.aw_got = 1'b1;
      nxt_q.awready = 1'b0;
      nxt_q.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q_ff.wready)
    begin
      nxt_q.w_got = 1'b1;
      nxt_q.wready = 1'b0;
      nxt_q.w_data = s_axi_wdata;
      nxt_q.w_strb = s_axi_wstrb;
    end
    case (q_ff.wst)
      MSCP_IDLE:
      begin
        if (q_ff.aw_got && q_ff.w_got)
        begin
          wr_fire = 1'b1;
          nxt_q.wst = MSCP_WRSP;
        end
      end
      MSCP_WRSP:
      begin
        nxt_q.bvalid = 1'b1;
        nxt_q.wst = MSCP_DONE;
      end
      MSCP_DONE:
      begin
        if (s_axi_bready)
        begin
          nxt_q.bvalid = 1'b0;
          nxt_q.aw_got = 1'b0;
          nxt_q.w_got = 1'b0;
          nxt_q.awready = 1'b1;
          nxt_q.wready = 1'b1;
          nxt_q.wst = MSCP_IDLE;
        end
      end
      default:
      begin
        nxt_q.wst = MSCP_IDLE;
      end
    endcase

    if (wr_fire)
    begin
      nxt_q.bresp = RESP_OKAY;
      case (q_ff.aw_addr)
        ADDR_SYS_CONTROL:
          nxt_q.ctl = (q_ff.ctl & ~wmask) | (q_ff.w_data[11:0] & wmask & CTL_WR_MASK);
        ADDR_DIO_CONTROL:
          nxt_q.dio_ctl = (q_ff.dio_ctl & ~wmask) | (q_ff.w_data[11:0] & wmask);
        ADDR_DIO_VALUE:
          if (q_ff.w_strb[0])
            nxt_q.dio_out = q_ff.w_data[DIO_W-1:0];
        ADDR_SYS_STATUS:
          nxt_q.bresp = RESP_OKAY;
        default:
          nxt_q.bresp = RESP_SLVERR;
      endcase
    end

    // read channel: one outstanding read, arready low while answer stands
    if (q_ff.rvalid && s_axi_rready)
    begin
      nxt_q.rvalid = 1'b0;
      nxt_q.arready = 1'b1;
    end
    if (s_axi_arvalid && q_ff.arready)
    begin
      rd_fire = 1'b1;
      case (s_axi_araddr)
        ADDR_SYS_CONTROL: rd_val = q_ff.ctl;
        ADDR_SYS_STATUS:
        begin
          sts_read = 1'b1;
          rd_val[STS_CONV_DONE] = q_ff.sts_conv;
          rd_val[STS_ROT_DONE] = q_ff.sts_rot;
          rd_val[STS_DIO_CHG] = q_ff.sts_dio;
          rd_val[STS_RES_VALID] = q_ff.sts_valid;
          rd_val[STS_IRQ_MINE] = q_ff.sts_mine;
        end
        ADDR_DIO_CONTROL: rd_val = q_ff.dio_ctl;
        ADDR_DIO_VALUE:   rd_val = {6'h00, (q_ff.dio_s2 & ~q_ff.dio_ctl[DIO_DIR_LSB +: DIO_W])
                                   | (q_ff.dio_out & q_ff.dio_ctl[DIO_DIR_LSB +: DIO_W])};
        default:          rd_ok = 1'b0;
      endcase
      nxt_q.arready = 1'b0;
      nxt_q.rvalid = 1'b1;
      nxt_q.rdata = {20'h00000, rd_val};
      nxt_q.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end

    // status: read clears all but results-valid, a same-cycle event wins over the clear
    if (sts_read)
    begin
      nxt_q.sts_conv = 1'b0;
      nxt_q.sts_rot = 1'b0;
      nxt_q.sts_dio = 1'b0;
      nxt_q.sts_mine = 1'b0;
      nxt_q.irq_hold = 1'b0;
    end
    if (ev_conv)
      nxt_q.sts_conv = 1'b1;
    if (ev_rot)
      nxt_q.sts_rot = 1'b1;
    if (ev_dio)
      nxt_q.sts_dio = 1'b1;
    if (ev_any)
      nxt_q.sts_mine = 1'b1;
    // valid drops when a new rotation starts, rises on completion
    if (q_ff.rot_start_s2)
      nxt_q.sts_valid = 1'b0;
    if (q_ff.rot_done_s2)
      nxt_q.sts_valid = 1'b1;

    // irq pin: pulse or level format
    if (ev_any && q_ff.ctl[CTL_IRQ_LEVEL])
      nxt_q.irq_hold = 1'b1;
    if (!q_ff.ctl[CTL_IRQ_LEVEL])
      nxt_q.irq_hold = 1'b0;
    // pulse mode: one cycle low per event; a held event level keeps the pin low throughout
    nxt_q.irq_n = ~(ev_any | nxt_q.irq_hold);

    // engine configuration and pin direction outputs
    nxt_q.conv_sel.u_en = q_ff.ctl[CTL_U_EN];
    nxt_q.conv_sel.aux_en = q_ff.ctl[CTL_AUX_EN];
    nxt_q.conv_sel.aux_num = {q_ff.ctl[CTL_AUX_SEL0], q_ff.ctl[CTL_AUX_SEL1]};
    nxt_q.sysclk_div = q_ff.ctl[CTL_CLK_HALF];
    nxt_q.rev_3of3 = q_ff.ctl[CTL_REV_3OF3];
    nxt_q.dio_oe = q_ff.dio_ctl[DIO_DIR_LSB +: DIO_W];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q_ff <= '0;
      q_ff.wst <= MSCP_IDLE;
      q_ff.awready <= 1'b1;
      q_ff.wready <= 1'b1;
      q_ff.arready <= 1'b1;
      q_ff.ctl <= CTL_RESET;
      q_ff.dio_ctl <= DIO_RESET;
      q_ff.irq_n <= 1'b1;
    end
    else if (clk_en)
    begin
      q_ff <= nxt_q;
    end
  end

  assign s_axi_awready = q_ff.awready;
  assign s_axi_wready  = q_ff.wready;
  assign s_axi_bvalid  = q_ff.bvalid;
  assign s_axi_bresp   = q_ff.bresp;
  assign s_axi_arready = q_ff.arready;
  assign s_axi_rvalid  = q_ff.rvalid;
  assign s_axi_rdata   = q_ff.rdata;
  assign s_axi_rresp   = q_ff.rresp;
  assign dio_out       = q_ff.dio_out;
  assign dio_oe        = q_ff.dio_oe;
  assign conv_sel      = q_ff.conv_sel;
  assign rev_3of3      = q_ff.rev_3of3;
  assign sysclk_div    = q_ff.sysclk_div;
  assign irq_n         = q_ff.irq_n;

endmodule
